// ==== rtl/rdm_src_out.sv ====
// Purpose: Source side: splits samples over lanes and drives the link.
// Assumes: Software sets mode bits before setting the run bit.
// Notes: A missing sample at a launch repeats the last set and flags it.
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module rdm_src_out
#(
    parameter int DIV_HALF = rdm_pkg::DIV_HALF_DEF
)
(
    input wire logic CLK,
    input wire logic RESET,
    rdm_link_if.src LNK,
    input wire logic [3:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output logic IRQ,
    input wire rdm_pkg::rdm_word_t SAMPLE,
    input wire logic SAMPLE_VALID,
    output logic SAMPLE_READY
);
    import rdm_pkg::*;

    initial
    begin
        if (DIV_HALF < 2 || DIV_HALF > 255)
            $error("rdm_src_out: DIV_HALF out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers.
    logic [CTRL_W-1:0] ctrl_r;
    logic [EV_W-1:0] stat_r;
    logic [EV_W-1:0] mask_r;
    logic [31:0] sets_r;
    logic [EV_W-1:0] ev;

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            ctrl_r <= CTRL_RST;
            mask_r <= MASK_RST;
        end
        else if (WR && ADDR == REG_CTRL)
            ctrl_r <= WDATA[CTRL_W-1:0];
        else if (WR && ADDR == REG_MASK)
            mask_r <= WDATA[EV_W-1:0];
    end

    // A new event in the clearing cycle survives the clear.
    always_ff @(posedge CLK)
    begin
        if (RESET)
            stat_r <= '0;
        else if (WR && ADDR == REG_STAT)
            stat_r <= (stat_r & ~WDATA[EV_W-1:0]) | ev;
        else
            stat_r <= stat_r | ev;
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
            RDATA <= '0;
        else if (RD)
        begin
            case (ADDR)
                REG_CTRL: RDATA <= {27'h0, ctrl_r};
                REG_STAT: RDATA <= {30'h0, stat_r};
                REG_MASK: RDATA <= {30'h0, mask_r};
                REG_SETS: RDATA <= sets_r;
                default: RDATA <= '0;
            endcase
        end
        else
            RDATA <= '0;
    end

    assign IRQ = |(stat_r & mask_r);

    ////////////////////////////////////////////////////////////////////////
    // Port clock divider; a launch is each edge in DDR, rising in SDR.
    logic [7:0] div_r;
    logic pclk_r;
    logic tick;
    logic launch;
    logic run;

    assign run = ctrl_r[CTRL_RUN];
    assign tick = run && div_r == 8'(DIV_HALF - 1);
    assign launch = tick && (ctrl_r[CTRL_DDR] || !pclk_r);

    always_ff @(posedge CLK)
    begin
        if (RESET || !run)
        begin
            div_r <= '0;
            pclk_r <= 1'b0;
        end
        else if (tick)
        begin
            div_r <= '0;
            pclk_r <= !pclk_r;
        end
        else
            div_r <= div_r + 8'h1;
    end

    assign LNK.port_data_clk = pclk_r;

    ////////////////////////////////////////////////////////////////////////
    // Gathering samples in lane order, then launching the set.
    rdm_word_t coll_r [LANES];
    logic [2:0] cnt_r;
    logic [2:0] n_lanes;
    logic take;

    assign n_lanes = rdm_lanes(ctrl_r[CTRL_MUX4]);
    assign SAMPLE_READY = run && cnt_r < n_lanes && !launch;
    assign take = SAMPLE_READY && SAMPLE_VALID;

    always_ff @(posedge CLK)
    begin
        if (RESET || !run)
            cnt_r <= '0;
        else if (launch && cnt_r == n_lanes)
            cnt_r <= '0;
        else if (take)
            cnt_r <= cnt_r + 3'h1;
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            for (int i = 0; i < LANES; i++)
                coll_r[i] <= '0;
        end
        else if (take)
            coll_r[cnt_r[1:0]] <= SAMPLE;
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            LNK.lane_par <= '0;
            sets_r <= '0;
            for (int i = 0; i < LANES; i++)
                LNK.lane_data[i] <= '0;
        end
        else if (launch && cnt_r == n_lanes)
        begin
            sets_r <= sets_r + 32'h1;
            for (int i = 0; i < LANES; i++)
            begin
                if (i < int'(n_lanes))
                begin
                    LNK.lane_data[i] <= ctrl_r[CTRL_XOR]
                        ? rdm_scramble(coll_r[i]) : coll_r[i];
                    LNK.lane_par[i] <= (i == 0 && ctrl_r[CTRL_BADPAR])
                        ^ rdm_parity(ctrl_r[CTRL_XOR]
                        ? rdm_scramble(coll_r[i]) : coll_r[i]);
                end
                else
                begin
                    LNK.lane_data[i] <= '0;
                    LNK.lane_par[i] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Events: error pin rises, or a launch found the set incomplete.
    logic [1:0] perr_s;
    logic perr_d;

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            perr_s <= 2'h0;
            perr_d <= 1'b0;
        end
        else
        begin
            perr_s <= {perr_s[0], LNK.par_err};
            perr_d <= perr_s[1];
        end
    end

    assign ev[EV_PARERR] = perr_s[1] && !perr_d;
    assign ev[EV_UNDER] = launch && cnt_r != n_lanes;
endmodule

// ==== rtl/rdm_pkg.sv ====
// Purpose: Shared constants and helpers for the multiplexed sample link.
// Assumes: Both ends are built with the same package.
// Notes: Scrambling is self-inverse, so one function serves both ends.
package rdm_pkg;
    localparam int SAMPLE_W = 14;
    localparam int LANES = 4;
    localparam int CONV_RATE_MSPS = 2300;
    localparam int PORT_RATE_2TO1_MWPS = 1150;
    localparam int PORT_RATE_4TO1_MWPS = 575;
    localparam int DIV_HALF_DEF = 8;
    localparam int EYE_CW_DEF = 8;
    // Register map of the source controller (byte addresses).
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam logic [3:0] REG_MASK = 4'h8;
    localparam logic [3:0] REG_SETS = 4'hc;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_MUX4 = 1;
    localparam int CTRL_DDR = 2;
    localparam int CTRL_XOR = 3;
    localparam int CTRL_BADPAR = 4;
    localparam int CTRL_W = 5;
    localparam int EV_PARERR = 0;
    localparam int EV_UNDER = 1;
    localparam int EV_W = 2;
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
    localparam logic [EV_W-1:0] MASK_RST = 2'h0;

    typedef logic [SAMPLE_W-1:0] rdm_word_t;

    // Even parity over a word as it travels on the wire.
    function automatic logic rdm_parity(input rdm_word_t w);
        return ^w;
    endfunction

    // Upper bits are XORed with the LSB; applying it twice restores data.
    function automatic rdm_word_t rdm_scramble(input rdm_word_t w);
        return w ^ {{(SAMPLE_W-1){w[0]}}, 1'b0};
    endfunction

    function automatic logic [2:0] rdm_lanes(input logic mux4);
        return mux4 ? 3'h4 : 3'h2;
    endfunction
endpackage

// ==== rtl/rdm_link_if.sv ====
// Purpose: Pin bundle between the sample source and the converter input.
// Assumes: Source drives clock, lanes and parity; converter drives error.
// Notes: Unused lanes in 2:1 mode are driven to zero.
`timescale 1ns/1ps
interface rdm_link_if;
    import rdm_pkg::*;
    logic port_data_clk;
    rdm_word_t lane_data [LANES];
    logic [LANES-1:0] lane_par;
    logic par_err;

    modport src
    (
        output port_data_clk,
        output lane_data,
        output lane_par,
        input par_err
    );
    modport dac
    (
        input port_data_clk,
        input lane_data,
        input lane_par,
        output par_err
    );
endinterface

// ==== rtl/rdm_eye_lock.sv ====
// Purpose: Places a capture strobe in the middle of each data window.
// Assumes: edge_in marks launch edges of the port clock, one cycle each.
// Notes: Lock needs two equal edge spacings in a row.
`timescale 1ns/1ps
module rdm_eye_lock
#(
    parameter int CW = rdm_pkg::EYE_CW_DEF
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic edge_in,
    output logic capture,
    output logic locked
);
    import rdm_pkg::*;

    initial
    begin
        if (CW < 4) $error("rdm_eye_lock: CW must be at least 4");
    end

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] per_r;
    logic locked_r;

    // The counter saturates so a stopped clock never wraps into a capture.
    always_ff @(posedge clk)
    begin
        if (reset)
            cnt_r <= '0;
        else if (edge_in)
            cnt_r <= '0;
        else if (cnt_r != '1)
            cnt_r <= cnt_r + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            per_r <= '0;
            locked_r <= 1'b0;
        end
        else if (edge_in)
        begin
            per_r <= cnt_r;
            locked_r <= (cnt_r == per_r) && (cnt_r != '1) && (cnt_r > 1);
        end
    end

    assign capture = locked_r && !edge_in && (cnt_r == (per_r >> 1));
    assign locked = locked_r;
endmodule

// ==== rtl/rdm_dac_in.sv ====
// Purpose: Converter-side input: rebuilds the full-rate sample stream.
// Assumes: Mode inputs are static and match the source configuration.
// Notes: Latency from launch edge to capture is fixed by the eye position; the code follows at the next converter edge.
`timescale 1ns/1ps
module rdm_dac_in
#(
    parameter int EYE_CW = rdm_pkg::EYE_CW_DEF
)
(
    input wire logic CLK,
    input wire logic RESET,
    rdm_link_if.dac LNK,
    input wire logic MUX4_SEL,
    input wire logic DDR_SEL,
    input wire logic PAR_EN,
    input wire logic XOR_EN,
    input wire logic CONV_CLK_POS,
    input wire logic CONV_CLK_NEG,
    output rdm_pkg::rdm_word_t DAC_CODE,
    output logic DAC_UPDATE,
    output logic PAR_ERR,
    output logic LOCKED
);
    import rdm_pkg::*;

    initial
    begin
        if (LANES != 4) $error("rdm_dac_in: four lanes required");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers. Clock and data share the same two-stage delay, so
    // their relative timing is kept intact.
    logic [1:0] port_data_clk_s;
    logic port_data_clk_d;
    rdm_word_t lane_s1 [LANES];
    rdm_word_t lane_s2 [LANES];
    logic [LANES-1:0] par_s1;
    logic [LANES-1:0] par_s2;
    logic [1:0] cpos_s;
    logic [1:0] cneg_s;
    logic conv_hi_d;

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            port_data_clk_s <= 2'h0;
            port_data_clk_d <= 1'b0;
            par_s1 <= '0;
            par_s2 <= '0;
            for (int i = 0; i < LANES; i++)
            begin
                lane_s1[i] <= '0;
                lane_s2[i] <= '0;
            end
        end
        else
        begin
            port_data_clk_s <= {port_data_clk_s[0], LNK.port_data_clk};
            port_data_clk_d <= port_data_clk_s[1];
            par_s1 <= LNK.lane_par;
            par_s2 <= par_s1;
            for (int i = 0; i < LANES; i++)
            begin
                lane_s1[i] <= LNK.lane_data[i];
                lane_s2[i] <= lane_s1[i];
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            cpos_s <= 2'h0;
            cneg_s <= 2'h0;
            conv_hi_d <= 1'b0;
        end
        else
        begin
            cpos_s <= {cpos_s[0], CONV_CLK_POS};
            cneg_s <= {cneg_s[0], CONV_CLK_NEG};
            conv_hi_d <= cpos_s[1] && !cneg_s[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Launch edge detection and eye centring.
    logic launch;
    logic capture;

    // In DDR every transition launches a set; in SDR only rising ones.
    assign launch = DDR_SEL ? (port_data_clk_s[1] ^ port_data_clk_d)
                            : (port_data_clk_s[1] && !port_data_clk_d);

    rdm_eye_lock #(.CW(EYE_CW)) u_eye
    (
        .clk(CLK),
        .reset(RESET),
        .edge_in(launch),
        .capture(capture),
        .locked(LOCKED)
    );

    ////////////////////////////////////////////////////////////////////////
    // Parity check on raw words, then optional descrambling.
    logic [2:0] n_lanes;
    logic bad_par;
    rdm_word_t word_c [LANES];

    assign n_lanes = rdm_lanes(MUX4_SEL);

    always_comb
    begin
        bad_par = 1'b0;
        for (int i = 0; i < LANES; i++)
        begin
            // Parity is judged on the wire form, before descrambling.
            if (i < int'(n_lanes)
                && rdm_parity(lane_s2[i]) != par_s2[i])
                bad_par = 1'b1;
            word_c[i] = XOR_EN ? rdm_scramble(lane_s2[i])
                               : lane_s2[i];
        end
    end

    // The flag is a level: it shows the verdict of the latest set.
    logic par_err_r;

    always_ff @(posedge CLK)
    begin
        if (RESET)
            par_err_r <= 1'b0;
        else if (capture)
            par_err_r <= PAR_EN && bad_par;
    end

    assign LNK.par_err = par_err_r;
    assign PAR_ERR = par_err_r;

    ////////////////////////////////////////////////////////////////////////
    // Set holding and round-robin playout.
    rdm_word_t set_r [LANES];
    logic [2:0] idx_r;
    logic conv_rise;

    assign conv_rise = cpos_s[1] && !cneg_s[1] && !conv_hi_d;

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            for (int i = 0; i < LANES; i++)
                set_r[i] <= '0;
        end
        else if (capture)
        begin
            for (int i = 0; i < LANES; i++)
                set_r[i] <= word_c[i];
        end
    end

    // A new set restarts playout at lane zero. A converter edge that
    // coincides with the capture plays the new lane zero at once; otherwise
    // lane zero waits for the next converter edge, so the distance varies.
    always_ff @(posedge CLK)
    begin
        if (RESET)
            idx_r <= n_lanes;
        else if (capture)
            idx_r <= conv_rise ? 3'h1 : 3'h0;
        else if (conv_rise && idx_r < n_lanes)
            idx_r <= idx_r + 3'h1;
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            DAC_CODE <= '0;
            DAC_UPDATE <= 1'b0;
        end
        else if (conv_rise && capture)
        begin
            DAC_CODE <= word_c[0];
            DAC_UPDATE <= 1'b1;
        end
        else if (conv_rise && idx_r < n_lanes)
        begin
            DAC_CODE <= set_r[idx_r[1:0]];
            DAC_UPDATE <= 1'b1;
        end
        else
            DAC_UPDATE <= 1'b0;
    end
endmodule

// ==== verif/rdm_link_asserts.sv ====
// Purpose: Concurrent checks on the link between the two ends.
// Assumes: One clock domain; lane 0 parity may be spoiled on purpose.
// Notes: Error timing is bounded loosely to leave room for the eye search.
`timescale 1ns/1ps
module rdm_link_asserts
#(
    parameter int DIV_HALF = rdm_pkg::DIV_HALF_DEF
)
(
    input logic CLK,
    input logic RESET,
    input logic port_data_clk,
    input rdm_pkg::rdm_word_t lane_data [rdm_pkg::LANES],
    input logic [rdm_pkg::LANES-1:0] lane_par,
    input logic par_err
);
    import rdm_pkg::*;
    localparam int AGE_MAX = 48;
    logic pclk_q;
    logic bad_now;
    logic [7:0] hold_cnt;
    logic [5:0] bad_age;
    logic [5:0] good_age;

    function automatic logic [5:0] up(input logic [5:0] a);
        return (a == 6'h3f) ? a : a + 6'h01;
    endfunction

    assign bad_now = lane_par != {^lane_data[3], ^lane_data[2],
        ^lane_data[1], ^lane_data[0]};

    ////////////////////////////////////////////////////////////////////////
    // Saturated at reset so a toggle right after release is never blamed.
    always_ff @(posedge CLK)
    begin
        pclk_q <= port_data_clk;
        if (RESET)
            hold_cnt <= 8'hff;
        else if (port_data_clk != pclk_q)
            hold_cnt <= 8'h00;
        else if (hold_cnt != 8'hff)
            hold_cnt <= hold_cnt + 8'h01;
    end

    always_ff @(posedge CLK)
    begin
        bad_age <= RESET ? 6'h3f : (bad_now ? 6'h00 : up(bad_age));
        good_age <= RESET ? 6'h3f : (bad_now ? up(good_age) : 6'h00);
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking dc @(posedge CLK);
    endclocking
    default disable iff (RESET);

    sequence s_idle;
        !port_data_clk && lane_par == 4'h0 && !par_err;
    endsequence

    a_par_lane_one: assert property (lane_par[1] == ^lane_data[1])
        else $error("lane 1 parity disagrees with its word");
    a_par_upper_lanes: assert property (
        lane_par[3:2] == {^lane_data[3], ^lane_data[2]})
        else $error("upper lane parity disagrees with its word");
    a_data_at_edge: assert property (
        $changed(lane_data[0]) || $changed(lane_data[1])
        |-> $changed(port_data_clk))
        else $error("lane data moved away from a port clock edge");
    a_par_at_edge: assert property (
        $changed(lane_par) |-> $changed(port_data_clk))
        else $error("lane parity moved away from a port clock edge");
    a_half_period: assert property (
        $changed(port_data_clk) |-> hold_cnt >= DIV_HALF - 1)
        else $error("port clock half period too short");
    a_reset_idle: assert property (
        disable iff (1'b0) RESET |=> s_idle)
        else $error("link not idle after reset");
    a_err_has_cause: assert property (
        $rose(par_err) |-> bad_age < AGE_MAX)
        else $error("parity error raised with good lanes");
    a_err_clears: assert property (
        $fell(par_err) |-> good_age < AGE_MAX)
        else $error("parity error dropped with bad lanes");
endmodule

// ==== verif/rdm_dac_mux_test.sv ====
// Purpose: Runs both link ends through every mode and checks the stream.
// Assumes: Converter mux and DDR pins always match the source control word; the xor pins may differ.
// Notes: Codes are checked as a sequence, so lock latency needs no figure.
`timescale 1ns/1ps
module rdm_dac_mux_test;
    import rdm_pkg::*;
    localparam int DH = 24;
    // Row bits: mux4, ddr, src xor, dac xor, parity on, bad parity, error.
    localparam logic [6:0] ROWS [7] = '{7'h04, 7'h44, 7'h20, 7'h7c, 7'h50,
        7'h27, 7'h42};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic conv = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic smp_vld = 1'b1;
    logic [6:0] mode = 7'h00;
    rdm_word_t smp = 14'h3ff0;
    logic mon_on = 1'b0;
    logic have_prev = 1'b0;
    rdm_word_t prev;
    rdm_word_t cur;
    rdm_word_t l0_q;
    rdm_word_t code;
    logic [31:0] rdata;
    logic [31:0] v;
    logic irq;
    logic smp_rdy;
    logic upd;
    logic perr;
    logic lock;
    int n_upd;
    int fail_count = 0;
    int checks = 0;

    rdm_link_if rdm_link_if_i ();
    rdm_src_out #(.DIV_HALF(DH)) rdm_src_out_i (.CLK(clk), .RESET(reset),
        .LNK(rdm_link_if_i.src), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .IRQ(irq), .SAMPLE(smp),
        .SAMPLE_VALID(smp_vld), .SAMPLE_READY(smp_rdy));
    rdm_dac_in rdm_dac_in_i (.CLK(clk), .RESET(reset),
        .LNK(rdm_link_if_i.dac), .MUX4_SEL(mode[6]), .DDR_SEL(mode[5]),
        .PAR_EN(mode[2]), .XOR_EN(mode[3]), .CONV_CLK_POS(conv),
        .CONV_CLK_NEG(~conv), .DAC_CODE(code), .DAC_UPDATE(upd),
        .PAR_ERR(perr), .LOCKED(lock));
    rdm_link_asserts #(.DIV_HALF(DH)) rdm_link_asserts_i (.CLK(clk),
        .RESET(reset), .port_data_clk(rdm_link_if_i.port_data_clk),
        .lane_data(rdm_link_if_i.lane_data),
        .lane_par(rdm_link_if_i.lane_par), .par_err(rdm_link_if_i.par_err));

    ////////////////////////////////////////////////////////////////////////
    function automatic rdm_word_t scr(input rdm_word_t w);
        return w ^ {{(SAMPLE_W-1){w[0]}}, 1'b0};
    endfunction

    // A lone scrambling end leaves scrambled codes; undo them here.
    assign cur = (mode[4] ^ mode[3]) ? scr(code) : code;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("errors %0d, checks %0d", fail_count, checks);
        if (fail_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge clk);
    endtask

    task automatic pulse_reset();
        reset <= 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
    endtask

    task automatic run_row(input logic [6:0] m);
        mode <= m;
        pulse_reset();
        mon_on <= 1'b1;
        wr_reg(REG_MASK, 32'h1);
        wr_reg(REG_CTRL, {27'h0, m[1], m[4], m[5], m[6], 1'b1});
        repeat (800) @(posedge clk);
        #1 chk(perr, m[0]);
        chk(rdm_link_if_i.par_err, m[0]);
        chk(irq, m[0]);
        chk(lock, 1);
        chk(n_upd > 15, 1);
        mon_on <= 1'b0;
        @(posedge clk);
        rd_reg(REG_STAT, v);
        chk(v[EV_PARERR], m[0]);
        if (m[0])
        begin
            wr_reg(REG_MASK, 32'h0);
            chk(irq, 0);
            wr_reg(REG_STAT, 32'h1);
            rd_reg(REG_STAT, v);
            chk(v[EV_PARERR], 0);
            wr_reg(REG_CTRL, {28'h0, m[4], m[5], m[6], 1'b1});
            repeat (150) @(posedge clk);
            chk(perr, 0);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #2.5 clk = ~clk;
    end

    // Converter clock is free running and unrelated in phase to clk.
    initial
    begin
        #1.3;
        forever #9.5 conv = ~conv;
    end

    always @(posedge clk)
    begin
        if (reset)
            smp <= 14'h3ff0;
        else if (smp_vld && smp_rdy)
            smp <= smp + 14'h0003;
    end

    always @(posedge clk)
    begin
        l0_q <= rdm_link_if_i.lane_data[0];
        if (!reset && rdm_link_if_i.lane_data[0] !== l0_q)
            chk(mode[5] | rdm_link_if_i.port_data_clk, 1);
        // The monitor owns its own state; a row restarts it by dropping
        // mon_on, so the stream check never spans a reset.
        if (!mon_on)
        begin
            have_prev <= 1'b0;
            n_upd <= 0;
        end
        else if (upd)
        begin
            if (have_prev)
                chk({18'h0, cur}, {18'h0, prev + 14'h0003});
            prev <= cur;
            have_prev <= 1'b1;
            n_upd <= n_upd + 1;
        end
    end

    initial
    begin
        #100000;
        fail_count++;
        print_verdict();
    end

    initial
    begin
        for (int i = 0; i < 7; i++)
            run_row(ROWS[i]);
        smp_vld <= 1'b0;
        mode <= 7'h00;
        pulse_reset();
        #1 chk({code, upd, lock, perr, irq, smp_rdy}, 0);
        @(posedge clk);
        rd_reg(REG_CTRL, v);
        chk(v, CTRL_RST);
        #1 chk(rdata, 0);
        @(posedge clk);
        rd_reg(REG_MASK, v);
        chk(v, MASK_RST);
        wr_reg(4'h2, 32'hffffffff);
        rd_reg(4'h2, v);
        chk(v, 0);
        wr_reg(REG_SETS, 32'h5);
        wr_reg(REG_MASK, 32'h2);
        wr_reg(REG_CTRL, 32'h1);
        repeat (200) @(posedge clk);
        rd_reg(REG_STAT, v);
        chk(v[EV_UNDER], 1);
        chk(irq, 1);
        rd_reg(REG_SETS, v);
        chk(v, 0);
        print_verdict();
    end
endmodule
